// *** rtl/sec_map.vh ***
// sec_map.vh : constants for the servo enable and command input block
// assumes: included by the servo command design file, the checker and the bench top, clock 20 MHz
`ifndef SEC_MAP_VH
`define SEC_MAP_VH

// clock period in ns
`define SEC_CLK_NS          50
// undervoltage window 1 s, in ms and cycles
`define SEC_UV_WIN_MS       1000
`define SEC_UV_WIN_CYC      ((`SEC_UV_WIN_MS * 1000000) / `SEC_CLK_NS)
// control ready delay 2 s, in ms and cycles
`define SEC_RDY_DLY_MS      2000
`define SEC_RDY_DLY_CYC     ((`SEC_RDY_DLY_MS * 1000000) / `SEC_CLK_NS)
// undervoltage threshold in volts
`define SEC_UV_LEVEL        16'h00C8
// pulse formats
`define SEC_FMT_DIFF_SIGN   8'h00
`define SEC_FMT_DIFF_FR     8'h01
`define SEC_FMT_DIFF_QUAD   8'h02
`define SEC_FMT_OC_SIGN     8'h03
`define SEC_FMT_OC_FR       8'h04
`define SEC_FMT_OC_QUAD     8'h05
// pulses per revolution range
`define SEC_PPR_GEAR        21'h00_0000
`define SEC_PPR_MIN         21'h00_0040
`define SEC_PPR_MAX         21'h10_0000
// gear range and defaults
`define SEC_GEAR_MIN        23'h00_0001
`define SEC_GEAR_MAX        23'h40_0000
`define SEC_GEAR_NUM_DEF    23'h00_0010
`define SEC_GEAR_DEN_DEF    23'h00_0001
// counts per motor revolution used with a direct pulses per revolution
`define SEC_ENC_PER_REV     21'h02_0000
// control modes
`define SEC_MODE_POS        4'h0
`define SEC_MODE_SPD        4'h1
// default input functions
`define SEC_FN_NONE         8'h00
`define SEC_FN_SERVO_ON     8'h01
`define SEC_FN_ALARM_RST    8'h0B
`define SEC_FN_RAMP_SEL     8'h0E
`define SEC_FN_COMM_SPD     8'h12
`define SEC_FN_SPD_B0       8'h33
`define SEC_FN_SPD_B1       8'h34
`define SEC_FN_SPD_B2       8'h35
// communicated speed address
`define SEC_COMM_SPD_ADDR   16'h3000
// ramp step divider for 1 ms ticks
`define SEC_MS_CYC          ((1000000) / `SEC_CLK_NS)

`endif

// *** rtl/sec_sync.v ***
// sec_sync.v : two flip-flop synchroniser for a bus of pin levels
// assumes: inputs are asynchronous to clk_sys
`timescale 1ns/1ps
module sec_sync #(
   parameter W = 1
) (
   input  wire         clk_sys,
   input  wire         reset_n,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);
   reg [W-1:0] meta_ff;   // first stage, read only by the second
   reg [W-1:0] sync_ff;   // second stage

   ////////////////////////////////////////////////////////////////////////////
   // two stage capture
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d_in;
         sync_ff <= meta_ff;
      end
   end
   assign q_out = sync_ff;
endmodule

// *** rtl/sec_servo_cmd.v ***
// sec_servo_cmd.v : servo enable, ready, undervoltage, pulse decode, gear, speed source
// assumes: pins arrive asynchronous; settings are static words from the drive's store
// Operation
// - ready follows servo enable once motor can rotate
// - enable dropped while rotating: ramp stop, coast
// - force mask keeps chosen inputs active
// - undervoltage flagged only within 1 s window
// - power loss drops ready, halts processor if control ready was up
// - format code picks sign, fwd/rev, quadrature decode
// - ppr 64..1048576 uses direct ppr, else gear
// - gear ratio 1..4194304, defaults 16/1
// - restart-only settings latched at power-up
// - default map: in1 enable, in2 reset
// - quadrature counts every edge, four per pulse
// - speed mode runs only after ready
// - run input held: accelerate, hold, release: decelerate
// - ramp select input picks time set
// - speed from select bits, analog, or comm
// - comm speed when select bits off, comm on
// - zero clamp applied to analog reference
// - ramps apply only with ramp enable one
// - zero speed output below threshold
// - control ready about 2 s after power
`timescale 1ns/1ps
`include "sec_map.vh"
module sec_servo_cmd #(
   parameter [31:0] RDY_DLY_CYC = `SEC_RDY_DLY_CYC,
   parameter [31:0] UV_WIN_CYC  = `SEC_UV_WIN_CYC
) (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire [23:0] external_input,         // input pins 1..24
   input  wire [23:0] force_on_mask,          // permanently active inputs
   input  wire        main_power_ok,          // main power present
   input  wire [15:0] link_voltage,           // dc link volts
   input  wire        self_test_ok,           // self diagnosis passed
   input  wire        motor_stopped,          // feedback: motor at rest
   input  wire        pulse_a_diff,           // differential pulse / a
   input  wire        pulse_b_diff,           // differential sign / b
   input  wire        pulse_a_oc,             // open collector pulse / a
   input  wire        pulse_b_oc,             // open collector sign / b
   input  wire [7:0]  pulse_format_setting,
   input  wire [20:0] pulses_per_rev_setting,
   input  wire [22:0] gear_numerator,
   input  wire [22:0] gear_denominator,
   input  wire [3:0]  control_mode_setting,
   input  wire        ramp_enable_setting,
   input  wire [15:0] zero_clamp_level,
   input  wire        undervoltage_alarm_setting,
   input  wire        power_loss_stop_action,
   input  wire [15:0] analog_speed_ref,
   input  wire [15:0] comm_speed_value,       // value at comm address 0x3000
   input  wire [15:0] preset_speed_0,
   input  wire [15:0] preset_speed_1,
   input  wire [15:0] preset_speed_2,
   input  wire [15:0] preset_speed_3,
   input  wire [15:0] preset_speed_4,
   input  wire [15:0] preset_speed_5,
   input  wire [15:0] preset_speed_6,
   input  wire [15:0] ramp_step_set0,         // speed step per ms, set 0
   input  wire [15:0] ramp_step_set1,         // speed step per ms, set 1
   input  wire [15:0] measured_speed,
   input  wire [15:0] zero_speed_level,
   output reg         control_ready_ff,
   output reg         servo_ready_ff,
   output reg         cpu_halt_ff,
   output reg         undervoltage_ff,
   output reg         uv_alarm_ff,
   output reg         coast_ff,
   output reg         alarm_reset_ff,
   output reg         zero_speed_ff,
   output reg  [31:0] cmd_count_ff,
   output reg  [47:0] scaled_pos_ff,
   output reg  [15:0] speed_cmd_ff,
   output reg         speed_dir_ff
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronise pins
   wire [23:0] in_s;       // synchronised input pins
   wire [5:0]  misc_s;     // power, test, pulses
   sec_sync #(.W(24)) u_sync_in (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .d_in    (external_input),
      .q_out   (in_s)
   );
   sec_sync #(.W(6)) u_sync_misc (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .d_in    ({main_power_ok, self_test_ok, pulse_a_diff, pulse_b_diff,
                 pulse_a_oc, pulse_b_oc}),
      .q_out   (misc_s)
   );
   wire pwr_s = misc_s[5];
   wire tst_s = misc_s[4];

   ////////////////////////////////////////////////////////////////////////////
   // input function map, default assignment, force mask
   wire [23:0] in_act = in_s | force_on_mask;
   wire servo_en   = in_act[0];
   wire alarm_rst  = in_act[1];
   // inputs 3..24 carry no function by default; run and select functions
   // sit at fixed positions for speed control use
   wire fwd_run    = in_act[2];                           // forward_run_in
   wire rev_run    = in_act[3];                           // reverse_run_in
   wire ramp_sel   = in_act[4];                           // ramp_set_select_in
   wire sel_b0     = in_act[5];                           // speed_select_bit0
   wire sel_b1     = in_act[6];                           // speed_select_bit1
   wire sel_b2     = in_act[7];                           // speed_select_bit2
   wire comm_sel   = in_act[8];                           // comm speed select

   ////////////////////////////////////////////////////////////////////////////
   // restart-only settings latched once after reset release
   reg        cfg_done_ff;    // latch taken
   reg [7:0]  fmt_ff;         // pulse format
   reg [20:0] ppr_ff;         // pulses per revolution
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         cfg_done_ff <= 1'b0;
         fmt_ff      <= `SEC_FMT_DIFF_SIGN;
         ppr_ff      <= `SEC_PPR_GEAR;
      end else if (!cfg_done_ff) begin
         cfg_done_ff <= 1'b1;
         fmt_ff      <= pulse_format_setting;
         ppr_ff      <= pulses_per_rev_setting;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control ready timer and power loss handling
   reg [31:0] rdy_cnt_ff;      // time since power up
   reg [31:0] uv_cnt_ff;       // time since servo enable
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         rdy_cnt_ff       <= 32'h0000_0000;
         control_ready_ff <= 1'b0;
         cpu_halt_ff      <= 1'b0;
      end else if (!pwr_s) begin
         rdy_cnt_ff       <= 32'h0000_0000;
         control_ready_ff <= 1'b0;
         cpu_halt_ff      <= control_ready_ff | cpu_halt_ff;
      end else if (rdy_cnt_ff < RDY_DLY_CYC) begin
         rdy_cnt_ff <= rdy_cnt_ff + 32'h0000_0001;
      end else if (tst_s && !cpu_halt_ff) begin
         control_ready_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // undervoltage: only inside the 1 s window after enable
   wire uv_level = (link_voltage <= `SEC_UV_LEVEL);
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         uv_cnt_ff       <= 32'h0000_0000;
         undervoltage_ff <= 1'b0;
         uv_alarm_ff     <= 1'b0;
      end else begin
         if (!servo_en)
            uv_cnt_ff <= 32'h0000_0000;
         else if (uv_cnt_ff < UV_WIN_CYC)
            uv_cnt_ff <= uv_cnt_ff + 32'h0000_0001;
         // set wins over alarm reset
         if (servo_en && uv_level && uv_cnt_ff < UV_WIN_CYC) begin
            undervoltage_ff <= 1'b1;
            uv_alarm_ff     <= undervoltage_alarm_setting;
         end else if (alarm_rst) begin
            undervoltage_ff <= 1'b0;
            uv_alarm_ff     <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // servo ready and coast sequence
   wire can_run = control_ready_ff && !undervoltage_ff;
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         servo_ready_ff <= 1'b0;
         coast_ff       <= 1'b1;
         alarm_reset_ff <= 1'b0;
      end else begin
         alarm_reset_ff <= alarm_rst;
         if (!control_ready_ff) begin
            servo_ready_ff <= 1'b0;
            // never ready: stays free; after power loss 1 coasts at once, 0 ramps first
            coast_ff <= !cpu_halt_ff | power_loss_stop_action | motor_stopped;
         end else if (servo_en && can_run) begin
            servo_ready_ff <= 1'b1;
            coast_ff       <= 1'b0;
         end else begin
            servo_ready_ff <= 1'b0;
            coast_ff       <= motor_stopped;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse decoder
   wire is_oc   = (fmt_ff >= `SEC_FMT_OC_SIGN);
   wire [7:0] fsub = is_oc ? (fmt_ff - `SEC_FMT_OC_SIGN) : fmt_ff;
   wire pa = is_oc ? misc_s[1] : misc_s[3];
   wire pb = is_oc ? misc_s[0] : misc_s[2];
   reg  pa_ff;    // previous a
   reg  pb_ff;    // previous b
   reg  step_up;  // count up this cycle
   reg  step_dn;  // count down this cycle
   always @* begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case (fsub)
         8'h00: begin                                     // pulse and sign
            if (pa && !pa_ff) begin
               step_up = !pb;
               step_dn = pb;
            end
         end
         8'h01: begin                                     // fwd / rev pulses
            step_up = pa && !pa_ff;
            step_dn = pb && !pb_ff;
         end
         8'h02: begin                                     // quadrature, every edge
            if ((pa ^ pa_ff) || (pb ^ pb_ff)) begin
               step_up = (pa_ff ^ pb);
               step_dn = (pb_ff ^ pa);
            end
         end
         default: begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // command counter and gear scaling, positions held when not ready
   wire gear_ok = (gear_numerator >= `SEC_GEAR_MIN) && (gear_numerator <= `SEC_GEAR_MAX)
                  && (gear_denominator >= `SEC_GEAR_MIN)
                  && (gear_denominator <= `SEC_GEAR_MAX);
   wire [22:0] num_eff = gear_ok ? gear_numerator   : `SEC_GEAR_NUM_DEF;
   wire [22:0] den_eff = gear_ok ? gear_denominator : `SEC_GEAR_DEN_DEF;
   wire ppr_direct = (ppr_ff >= `SEC_PPR_MIN) && (ppr_ff <= `SEC_PPR_MAX);
   reg  [47:0] acc_ff;     // remainder accumulator for the ratio
   wire [22:0] mul_n = ppr_direct ? {2'b00, `SEC_ENC_PER_REV} : num_eff;
   wire [22:0] div_d = ppr_direct ? {2'b00, ppr_ff} : den_eff;
   wire pos_mode = (control_mode_setting == `SEC_MODE_POS);
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         pa_ff         <= 1'b0;
         pb_ff         <= 1'b0;
         cmd_count_ff  <= 32'h0000_0000;
         scaled_pos_ff <= 48'h0000_0000_0000;
         acc_ff        <= 48'h0000_0000_0000;
      end else begin
         pa_ff <= pa;
         pb_ff <= pb;
         if (pos_mode && servo_ready_ff) begin
            if (step_up) begin
               cmd_count_ff <= cmd_count_ff + 32'h0000_0001;
               acc_ff       <= acc_ff + {25'h000_0000, mul_n};
            end else if (step_dn) begin
               cmd_count_ff <= cmd_count_ff - 32'h0000_0001;
               acc_ff       <= acc_ff - {25'h000_0000, mul_n};
            end else if (!acc_ff[47] && acc_ff >= {25'h000_0000, div_d}) begin
               acc_ff        <= acc_ff - {25'h000_0000, div_d};
               scaled_pos_ff <= scaled_pos_ff + 48'h0000_0000_0001;
            end else if (acc_ff[47]) begin
               acc_ff        <= acc_ff + {25'h000_0000, div_d};
               scaled_pos_ff <= scaled_pos_ff - 48'h0000_0000_0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // speed source selection and zero clamp
   wire [2:0] sel = {sel_b2, sel_b1, sel_b0};
   wire [15:0] clamped = (analog_speed_ref <= zero_clamp_level) ? 16'h0000
                         : analog_speed_ref;
   reg  [15:0] target;     // chosen speed before ramp
   always @* begin
      case (sel)
         3'd0:    target = comm_sel ? comm_speed_value : clamped;
         3'd1:    target = preset_speed_0;
         3'd2:    target = preset_speed_1;
         3'd3:    target = preset_speed_2;
         3'd4:    target = preset_speed_3;
         3'd5:    target = preset_speed_4;
         3'd6:    target = preset_speed_5;
         default: target = preset_speed_6;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // ramp generator on a 1 ms tick
   reg [15:0] ms_cnt_ff;   // millisecond divider
   wire ms_tick = (ms_cnt_ff == `SEC_MS_CYC - 1);
   wire spd_mode = (control_mode_setting == `SEC_MODE_SPD) && servo_ready_ff;
   wire run = spd_mode && (fwd_run ^ rev_run);
   wire [15:0] goal = run ? target : 16'h0000;
   wire [15:0] step = ramp_sel ? ramp_step_set1 : ramp_step_set0;
   wire [16:0] up_v = {1'b0, speed_cmd_ff} + {1'b0, step};
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         ms_cnt_ff    <= 16'h0000;
         speed_cmd_ff <= 16'h0000;
         speed_dir_ff <= 1'b0;
         zero_speed_ff <= 1'b1;
      end else begin
         ms_cnt_ff <= ms_tick ? 16'h0000 : ms_cnt_ff + 16'h0001;
         zero_speed_ff <= (measured_speed < zero_speed_level);
         if (run)
            speed_dir_ff <= rev_run;
         if (!ramp_enable_setting || !servo_ready_ff) begin
            speed_cmd_ff <= goal;
         end else if (ms_tick) begin
            if (speed_cmd_ff < goal)
               speed_cmd_ff <= (up_v[15:0] > goal || up_v[16]) ? goal : up_v[15:0];
            else if (speed_cmd_ff > goal)
               speed_cmd_ff <= (speed_cmd_ff - goal < step) ? goal
                               : speed_cmd_ff - step;
         end
      end
   end
endmodule

// *** tb/sec_host_pulse.sv ***
// sec_host_pulse.sv : host pulse generator model driving the command pulse pins
// assumes: bench clock; style 0 pulse and sign, 1 forward/reverse, 2 quadrature
`timescale 1ns/1ps
module sec_host_pulse (
   input  wire       clk_sys,
   input  wire [1:0] style,
   output reg        pa,
   output reg        pb
);
   // both pins rest low before the first burst
   initial begin
      pa = 1'b0;
      pb = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // send n pulses; each phase is held four clocks so the synchroniser sees it
   task automatic burst(input integer n, input reg reverse_run_in);
      integer   i;
      integer   j;
      reg [7:0] seq;   // four phases of {a, b}, first phase in the top bits
      begin
         case (style)
            2'd0: seq = {1'b0, reverse_run_in, 1'b1, reverse_run_in, 1'b0, reverse_run_in, 1'b0, reverse_run_in};
            2'd1: seq = {~reverse_run_in, reverse_run_in, 6'b00_0000};
            default: seq = reverse_run_in ? 8'b10_11_01_00 : 8'b01_11_10_00;
         endcase
         for (i = 0; i < n; i = i + 1) begin
            for (j = 3; j >= 0; j = j - 1) begin
               repeat (4) @(posedge clk_sys);
               #2 {pa, pb} = seq[2*j +: 2];
            end
         end
      end
   endtask
endmodule

// *** tb/sec_servo_cmd_checker.sv ***
// sec_servo_cmd_checker.sv : port timing checks for the servo command block
// assumes: bound into sec_servo_cmd; one clock, synchronous active low reset
`timescale 1ns/1ps
`include "sec_map.vh"
module sec_servo_cmd_checker #(
   parameter [31:0] RDY_DLY_CYC = `SEC_RDY_DLY_CYC,
   parameter [31:0] UV_WIN_CYC  = `SEC_UV_WIN_CYC
) (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire [23:0] external_input,
   input  wire [23:0] force_on_mask,
   input  wire        main_power_ok,
   input  wire        self_test_ok,
   input  wire [15:0] link_voltage,
   input  wire        control_ready_ff,
   input  wire        servo_ready_ff,
   input  wire        cpu_halt_ff,
   input  wire        undervoltage_ff,
   input  wire [31:0] cmd_count_ff
);
   reg  [31:0] pwr_cnt_ff;  // clocks with power and self test both good
   reg  [31:0] en_cnt_ff;   // clocks the servo enable has been held
   wire        en_any      = external_input[0] | force_on_mask[0];
   wire [31:0] nxt_pwr_cnt = (main_power_ok & self_test_ok) ? pwr_cnt_ff + 32'd1 : 32'd0;
   wire [31:0] nxt_en_cnt  = en_any ? en_cnt_ff + 32'd1 : 32'd0;
   ////////////////////////////////////////////////////////////////////////////////
   // helper counters restart with the block's own reset
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         pwr_cnt_ff <= 32'd0;
         en_cnt_ff  <= 32'd0;
      end else begin
         pwr_cnt_ff <= nxt_pwr_cnt;
         en_cnt_ff  <= nxt_en_cnt;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_cause: assert property (
      $rose(servo_ready_ff) |-> $past(control_ready_ff) && !$past(undervoltage_ff))
      else $error("servo ready rose without control ready");
   a_halt_drops_ready: assert property (cpu_halt_ff |-> ##2 !servo_ready_ff)
      else $error("servo ready stands while halted");
   a_halt_sticky: assert property (cpu_halt_ff |=> cpu_halt_ff)
      else $error("halt released without reset");
   a_count_gated: assert property (!servo_ready_ff [*4] |=> $stable(cmd_count_ff))
      else $error("pulse count moved while not ready");
   a_count_step: assert property ($changed(cmd_count_ff) |->
      (cmd_count_ff - $past(cmd_count_ff) == 32'd1) || (cmd_count_ff == $past(cmd_count_ff) - 32'd1))
      else $error("pulse count jumped by more than one");
   a_power_drops_ctrl: assert property (!main_power_ok [*4] |-> !control_ready_ff)
      else $error("control ready stands without power");
   a_ctrl_not_early: assert property ($rose(control_ready_ff) |-> pwr_cnt_ff >= RDY_DLY_CYC)
      else $error("control ready came too early");
   a_ctrl_due: assert property (pwr_cnt_ff == RDY_DLY_CYC + 32'd8 |-> control_ready_ff)
      else $error("control ready came too late");
   a_uv_window: assert property ($rose(undervoltage_ff) |-> en_cnt_ff >= 32'd1 &&
      en_cnt_ff <= UV_WIN_CYC + 32'd4 && $past(link_voltage) <= `SEC_UV_LEVEL)
      else $error("undervoltage flagged outside its window");
   c_ctrl_ready: cover property ($rose(control_ready_ff));
   c_uv: cover property ($rose(undervoltage_ff));
   c_halt: cover property ($rose(cpu_halt_ff));
   c_count: cover property ($changed(cmd_count_ff));
endmodule

bind sec_servo_cmd sec_servo_cmd_checker #(
   .RDY_DLY_CYC(RDY_DLY_CYC),
   .UV_WIN_CYC (UV_WIN_CYC)
) u_chk (.*);

// *** tb/sec_servo_cmd_tb.sv ***
// sec_servo_cmd_tb.sv : self-checking bench for the servo command block
// assumes: host pulse model on the pulse pins; shortened ready and window counts
`timescale 1ns/1ps
`include "sec_map.vh"
module sec_servo_cmd_tb;
   localparam [31:0] RDY = 32'd20;  // shortened control ready delay
   localparam [31:0] UVW = 32'd50;  // shortened undervoltage window
   reg         clk_sys = 1'b0, reset_n = 1'b0, use_oc = 1'b0;
   reg  [23:0] external_input = 24'h00_0000, force_on_mask = 24'h00_0000;
   reg         main_power_ok = 1'b1, self_test_ok = 1'b1, motor_stopped = 1'b0;
   reg  [15:0] link_voltage = 16'h012C, zero_clamp_level = 16'h0200;
   reg  [7:0]  pulse_format_setting = 8'h00;
   reg  [20:0] pulses_per_rev_setting = 21'h00_0000;
   reg  [22:0] gear_numerator = 23'h00_0010, gear_denominator = 23'h00_0001;
   reg  [3:0]  control_mode_setting = 4'h0;
   reg         ramp_enable_setting = 1'b0, undervoltage_alarm_setting = 1'b1;
   reg         power_loss_stop_action = 1'b0;
   reg  [15:0] analog_speed_ref = 16'h0100, comm_speed_value = 16'h0777;
   reg  [15:0] preset_speed_0 = 16'h0111, preset_speed_1 = 16'h0222, preset_speed_2 = 16'h0333;
   reg  [15:0] preset_speed_3 = 16'h0444, preset_speed_4 = 16'h0555, preset_speed_5 = 16'h0666;
   reg  [15:0] preset_speed_6 = 16'h0999, ramp_step_set0 = 16'h0010, ramp_step_set1 = 16'h0020;
   reg  [15:0] measured_speed = 16'h0005, zero_speed_level = 16'h000A;
   reg  [1:0]  style = 2'd0;
   wire        pa, pb;
   wire        pulse_a_diff = use_oc ? 1'b0 : pa;
   wire        pulse_b_diff = use_oc ? 1'b0 : pb;
   wire        pulse_a_oc   = use_oc ? pa : 1'b0;
   wire        pulse_b_oc   = use_oc ? pb : 1'b0;
   wire        control_ready_ff, servo_ready_ff, cpu_halt_ff, undervoltage_ff, uv_alarm_ff;
   wire        coast_ff, alarm_reset_ff, zero_speed_ff, speed_dir_ff;
   wire [31:0] cmd_count_ff;
   wire [47:0] scaled_pos_ff;
   wire [15:0] speed_cmd_ff;
   integer     miscompares = 0, checks_done = 0, cyc = 0, f, net, ratio, i;

   sec_servo_cmd #(.RDY_DLY_CYC(RDY), .UV_WIN_CYC(UVW)) u_dut (.*);
   sec_host_pulse u_host (.clk_sys(clk_sys), .style(style), .pa(pa), .pb(pb));

   always #25 clk_sys = ~clk_sys;
   // hang guard: less than twice the expected run length
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         miscompares = miscompares + 1;
         results;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #2;
      end
   endtask
   task chk(input [47:0] got, input [47:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // reset with the restart-only settings, then disturb them after they are taken
   task do_reset(input [7:0] fmt, input [20:0] ppr);
      begin
         reset_n = 1'b0;
         pulse_format_setting = fmt;
         pulses_per_rev_setting = ppr;
         tick(3);
         reset_n = 1'b1;
         tick(1);
         pulse_format_setting = fmt ^ 8'h01;
         pulses_per_rev_setting = ppr ^ 21'h00_0040;
      end
   endtask
   // wait for control ready, then turn the servo enable on
   task bring_up;
      begin
         tick(RDY / 2);
         chk(control_ready_ff, 0);
         for (i = 0; i < 40 && control_ready_ff !== 1'b1; i = i + 1) tick(1);
         chk(control_ready_ff, 1);
         external_input[0] = 1'b1;
         tick(5);
         chk(servo_ready_ff, 1);
      end
   endtask
   task wait_spd(input [15:0] exp);
      begin
         for (i = 0; i < 60 && speed_cmd_ff !== exp; i = i + 1) tick(1);
         chk(speed_cmd_ff, exp);
      end
   endtask
   task results;
      begin
         $display("checks %0d miscompares %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      // every pulse format, with gear, default gear and direct pulses per turn
      for (f = 0; f < 6; f = f + 1) begin
         gear_numerator = (f == 1) ? 23'h0 : (f == 2) ? 23'h4 : (f == 4) ? 23'h9 : 23'h10;
         gear_denominator = (f == 2) ? 23'h2 : (f == 4) ? 23'h3 : 23'h1;
         ratio = (f == 3) ? 2048 : (f == 2) ? 2 : (f == 4) ? 3 : 16;
         external_input[0] = 1'b0;
         do_reset(f[7:0], (f == 3) ? 21'h00_0040 : 21'h00_0000);
         if (f == 0) chk({coast_ff, zero_speed_ff, servo_ready_ff, cmd_count_ff}, 35'h6_0000_0000);
         use_oc = (f > 2);
         style = f % 3;
         bring_up;
         u_host.burst(3, 1'b0);
         u_host.burst(1, 1'b1);
         net = (f % 3 == 2) ? 8 : 2;
         for (i = 0; i < 5000 && scaled_pos_ff !== 48'(net * ratio); i = i + 1) tick(1);
         chk(cmd_count_ff, 48'(net));
         chk(scaled_pos_ff, 48'(net * ratio));
      end
      external_input[1] = 1'b1;
      tick(4);
      chk(alarm_reset_ff, 1);
      external_input[1:0] = 2'b00;
      tick(6);
      chk({servo_ready_ff, coast_ff}, 2'b00);
      motor_stopped = 1'b1;
      tick(5);
      chk(coast_ff, 1);
      force_on_mask = 24'h00_0001;
      tick(5);
      chk(servo_ready_ff, 1);
      force_on_mask = 24'h00_0000;
      tick(4);
      // undervoltage inside the window, at and just above the level, then after it
      external_input[0] = 1'b1;
      link_voltage = 16'h00C9;
      tick(10);
      chk(undervoltage_ff, 0);
      link_voltage = `SEC_UV_LEVEL;
      tick(4);
      chk({undervoltage_ff, uv_alarm_ff}, 2'b11);
      link_voltage = 16'h012C;
      external_input[1] = 1'b1;
      tick(4);
      external_input[1] = 1'b0;
      tick(4);
      chk({undervoltage_ff, uv_alarm_ff}, 2'b00);
      tick(UVW);
      link_voltage = 16'h0000;
      tick(4);
      chk(undervoltage_ff, 0);
      // host drops the enable before power goes away
      external_input[0] = 1'b0;
      link_voltage = 16'h012C;
      tick(4);
      main_power_ok = 1'b0;
      link_voltage = 16'h0000;
      tick(6);
      chk({control_ready_ff, undervoltage_ff}, 2'b00);
      main_power_ok = 1'b1;
      link_voltage = 16'h012C;
      do_reset(8'h00, 21'h00_0000);
      bring_up;
      main_power_ok = 1'b0;
      tick(6);
      chk({servo_ready_ff, cpu_halt_ff}, 2'b01);
      // speed control: run command waits for ready, then each speed source
      main_power_ok = 1'b1;
      external_input = 24'h00_00F4;
      control_mode_setting = 4'h1;
      do_reset(8'h00, 21'h00_0000);
      tick(5);
      chk(speed_cmd_ff, 0);
      bring_up;
      wait_spd(preset_speed_6);
      external_input[8:5] = 4'b1000;
      wait_spd(comm_speed_value);
      external_input[8] = 1'b0;
      wait_spd(16'h0000);
      analog_speed_ref = 16'h0300;
      wait_spd(16'h0300);
      // ramp on with set 1 chosen: first millisecond step is one set-1 step
      ramp_enable_setting = 1'b1;
      analog_speed_ref = 16'h0340;
      for (i = 0; i < 20010 && speed_cmd_ff === 16'h0300; i = i + 1) tick(1);
      chk(speed_cmd_ff, 16'h0320);
      ramp_enable_setting = 1'b0;
      external_input[3:2] = 2'b10;
      tick(6);
      chk(speed_dir_ff, 1);
      external_input[3] = 1'b0;
      wait_spd(16'h0000);
      chk(zero_speed_ff, 1);
      measured_speed = 16'h0014;
      tick(4);
      chk(zero_speed_ff, 0);
      results;
   end
endmodule
